// *** uart_baud_and_address_match.sv ***
// Purpose: timer-overflow baud generation, 8/9-bit framing, address filter
// Assumes: inputs synchronous to i_mclk; count clocks are one-cycle pulses
// Notes:   received words pass a two-entry buffer before the consumer
//
// Notes on behaviour
// (R01) timer1 source: 32 or 16 overflows per bit
// (R02) timer1 overflows every 256 minus reload ticks
// (R03) wide timers: 16 overflows per bit always
// (R04) wide timers overflow every 65536 minus reload ticks
// (R05) 9-bit frame: start, 8 data LSB first, ninth, stop
// (R06) 9-bit mode shares the 8-bit rate generation
// (R07) master sends address ninth=1, data ninth=0
// (R08) masked and broadcast addresses both valid
// (R09) masked compare only where mask bit set
// (R10) filter on: accept if ninth set and matched; in 8-bit mode the code accepts on the stop bit alone, with no match
// (R11) filter on: rejected bytes neither loaded nor flagged
// (R12) software clears filter after address, resets later
// (R13) broadcast is address OR mask, zeros ignored
// (R14) all-ones address matches in every slave
// (R15) tx and rx sources chosen independently
// (R16) rate doubler is zero after reset
// (R17) data to buffer, ninth bit to flag
// (R18) match settled before stop-bit update

module uart_baud_and_address_match
  import uart_pkg::*;
(
  // clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_sys_rst,
  // rate sources
  input  wire logic                      i_timer1_count_clock,
  input  wire logic [T1_W-1:0]           i_timer1_reload_byte,
  input  wire logic [NUM_WIDE-1:0]       i_wide_timer_count_clock,
  input  wire logic [NUM_WIDE-1:0][WT_W-1:0] i_wide_timer_reload_value,
  // configuration
  input  wire logic                      i_rate_doubler_bit,
  input  wire logic [1:0]                i_tx_rate_source_sel,
  input  wire logic [1:0]                i_rx_rate_source_sel,
  input  wire logic                      i_nine_bit_mode,
  input  wire logic                      i_multiproc_filter_enable,
  input  wire logic [7:0]                i_slave_addr_value,
  input  wire logic [7:0]                i_slave_addr_mask,
  // transmit
  input  wire logic [7:0]                i_tx_data,
  input  wire logic                      i_tx_ninth,
  input  wire logic                      i_tx_valid,
  output logic                           o_tx_ready,
  output logic                           o_tx_done,
  output logic                           o_txd,
  // receive
  input  wire logic                      i_rxd,
  input  wire logic                      i_rx_read,
  output logic                           o_receive_done_flag,
  output logic [7:0]                     o_serial_data_buffer,
  output logic                           o_received_ninth_bit,
  output logic                           o_rx_overrun
);

  // ****************************************
  // timers
  // ****************************************
  logic [T1_W-1:0]               t1_cnt_q;
  logic                          t1_ovf;
  logic [NUM_WIDE-1:0][WT_W-1:0] wt_cnt_q;
  logic [NUM_WIDE-1:0]           wt_ovf;
  logic                          doubler_q;

  // roll from all ones back to the reload value
  assign t1_ovf = i_timer1_count_clock && (t1_cnt_q == T1_TOP);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      t1_cnt_q <= T1_RESET;
    end else if (t1_ovf) begin
      t1_cnt_q <= i_timer1_reload_byte; // R02
    end else if (i_timer1_count_clock) begin
      t1_cnt_q <= t1_cnt_q + 1'b1;
    end
  end

  for (genvar w = 0; w < NUM_WIDE; w++) begin : g_wide
    assign wt_ovf[w] = i_wide_timer_count_clock[w] &&
                       (wt_cnt_q[w] == WT_TOP);
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        wt_cnt_q[w] <= WT_RESET;
      end else if (wt_ovf[w]) begin
        wt_cnt_q[w] <= i_wide_timer_reload_value[w]; // R04
      end else if (i_wide_timer_count_clock[w]) begin
        wt_cnt_q[w] <= wt_cnt_q[w] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      doubler_q <= DOUBLER_RESET; // R16
    end else begin
      doubler_q <= i_rate_doubler_bit;
    end
  end

  // ****************************************
  // baud paths: index 0 transmit, 1 receive
  // ****************************************
  logic [1:0][1:0] path_sel;
  logic [1:0]      path_ovf;
  logic [1:0]      path_slow;
  logic [1:0]      half_q;
  logic [1:0]      samp_tick;

  assign path_sel[0] = i_tx_rate_source_sel; // R15
  assign path_sel[1] = i_rx_rate_source_sel; // R15

  // the same chain serves 8- and 9-bit frames
  for (genvar p = 0; p < 2; p++) begin : g_path // R06
    assign path_ovf[p]  = (path_sel[p] == SRC_TIMER1) ? t1_ovf :
                          wt_ovf[path_sel[p] - 2'h1];
    // only timer1 has the extra halving stage
    assign path_slow[p] = (path_sel[p] == SRC_TIMER1) && !doubler_q; // R01 R03
    assign samp_tick[p] = path_ovf[p] && (!path_slow[p] || half_q[p]);
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        half_q[p] <= 1'b0;
      end else if (path_ovf[p] && path_slow[p]) begin
        half_q[p] <= !half_q[p];
      end
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_left_q;
  logic [3:0]  tx_samp_q;
  logic        tx_bit_tick;
  logic        tx_load;
  logic        tx_done_q;

  assign o_tx_ready  = (tx_left_q == 4'h0);
  assign tx_load     = i_tx_valid && o_tx_ready;
  assign tx_bit_tick = samp_tick[0] && (tx_samp_q == SAMPLE_LAST);
  assign o_txd       = tx_sh_q[0];
  assign o_tx_done   = tx_done_q;

  // the sample count restarts on load so every bit gets full width
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || tx_load) begin
      tx_samp_q <= 4'h0;
    end else if (samp_tick[0]) begin
      tx_samp_q <= tx_samp_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tx_sh_q   <= TX_IDLE_LINE;
      tx_left_q <= 4'h0;
    end else if (tx_load) begin
      tx_sh_q   <= {1'b1, i_nine_bit_mode ? i_tx_ninth : 1'b1,
                    i_tx_data, 1'b0}; // R05
      tx_left_q <= i_nine_bit_mode ? FRAME_BITS_9 : FRAME_BITS_8;
    end else if (tx_bit_tick && (tx_left_q != 4'h0)) begin
      tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
      tx_left_q <= tx_left_q - 1'b1;
    end
  end

  // done marks the start of the stop bit
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= tx_bit_tick && (tx_left_q == 4'h2);
    end
  end

  // ****************************************
  // receiver and address filter
  // ****************************************
  rx_state_t  rx_st_q;
  logic [3:0] rx_samp_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic       rx_ninth_q;
  logic       match_q;
  logic       rx_mid;
  logic [7:0] rx_full;
  logic [7:0] bcast;
  logic       masked_hit;
  logic       bcast_hit;
  logic       rx_stop;
  logic       rx_ninth_fin;
  logic       rx_accept;
  logic       buf_ready;
  logic       rx_push;
  logic       ovr_q;
  rx_word_t   buf_out;

  assign rx_mid  = samp_tick[1] && (rx_samp_q == SAMPLE_MID);
  assign rx_full = {i_rxd, rx_sh_q[7:1]};
  assign bcast   = i_slave_addr_value | i_slave_addr_mask; // R13
  assign masked_hit = ((rx_full ^ i_slave_addr_value) &
                       i_slave_addr_mask) == BYTE_ZERO; // R09
  // ones of the broadcast pattern must be ones, so 0xFF always hits
  assign bcast_hit  = (rx_full & bcast) == bcast; // R13 R14

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || rx_st_q == RX_IDLE) begin
      rx_samp_q <= 4'h0;
    end else if (samp_tick[1]) begin
      rx_samp_q <= rx_samp_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_st_q <= RX_IDLE;
      rx_idx_q <= 3'h0;
    end else begin
      unique case (rx_st_q)
        RX_IDLE: begin
          if (!i_rxd) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          // a start bit gone high at mid-bit was a glitch
          if (rx_mid) begin
            rx_st_q  <= i_rxd ? RX_IDLE : RX_DATA;
            rx_idx_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_idx_q <= rx_idx_q + 1'b1;
            if (rx_idx_q == DATA_LAST) begin
              rx_st_q <= i_nine_bit_mode ? RX_NINTH : RX_STOP;
            end
          end
        end
        RX_NINTH: begin
          if (rx_mid) begin
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // data LSB first; match is frozen once the eighth bit is in
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_sh_q    <= BYTE_ZERO;
      rx_ninth_q <= 1'b0;
      match_q    <= 1'b0;
    end else if (rx_mid && rx_st_q == RX_DATA) begin
      rx_sh_q <= rx_full;
      if (rx_idx_q == DATA_LAST) begin
        match_q <= masked_hit || bcast_hit; // R08 R18
      end
    end else if (rx_mid && rx_st_q == RX_NINTH) begin
      rx_ninth_q <= i_rxd;
    end
  end

  // in 8-bit mode the stop bit stands in for the ninth bit
  assign rx_stop      = rx_mid && (rx_st_q == RX_STOP);
  assign rx_ninth_fin = i_nine_bit_mode ? rx_ninth_q : i_rxd; // R17
  assign rx_accept    = !i_multiproc_filter_enable ||
                        (rx_ninth_fin &&
                         (match_q || !i_nine_bit_mode)); // R10 R11
  assign rx_push      = rx_stop && rx_accept; // R11

  // a full buffer drops the word and reports it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= rx_push && !buf_ready;
    end
  end

  two_entry_buf #(
    .WIDTH ($bits(rx_word_t)),
    .DEPTH (RXBUF_DEPTH)
  ) u_rx_buf (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (rx_push),
    .o_in_ready  (buf_ready),
    .i_in_data   ({rx_ninth_fin, rx_sh_q}), // R17
    .o_out_valid (o_receive_done_flag),
    .i_out_ready (i_rx_read),
    .o_out_data  (buf_out)
  );

  assign o_serial_data_buffer = buf_out.data;
  assign o_received_ninth_bit = buf_out.ninth;
  assign o_rx_overrun         = ovr_q;

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] h_ovf_q;
  logic       h_seen_q;
  logic [5:0] h_want;

  assign h_want = path_slow[0] ? OVF_PER_BIT_SLOW : OVF_PER_BIT_FAST;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || tx_load || $changed(path_sel[0]) ||
        $changed(doubler_q)) begin
      h_ovf_q  <= 6'h00;
      h_seen_q <= 1'b0;
    end else if (tx_bit_tick) begin
      h_ovf_q  <= 6'h00;
      h_seen_q <= 1'b1;
    end else if (path_ovf[0]) begin
      h_ovf_q  <= h_ovf_q + 1'b1;
    end
  end

  AST_BIT_PERIOD: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R01 R03
    tx_bit_tick && h_seen_q |-> h_ovf_q + 6'h01 == h_want)
    else $error("bit period overflow count wrong");
  AST_T1_RELOAD: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R02
    t1_ovf |=> t1_cnt_q == $past(i_timer1_reload_byte))
    else $error("timer1 did not reload");
  AST_WT_RELOAD: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R04
    wt_ovf[0] |=> wt_cnt_q[0] == $past(i_wide_timer_reload_value[0]))
    else $error("wide timer did not reload");
  AST_TX_START: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R05
    tx_load |=> !o_txd && !o_tx_ready)
    else $error("frame did not open with start bit");
  AST_TX_STOP: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R05
    o_tx_done |-> o_txd && tx_left_q == 4'h1)
    else $error("done not at stop bit");
  AST_FILTER_NINTH: assert property (@(posedge i_mclk) // R10 R11
    disable iff (i_sys_rst)
    rx_push && i_multiproc_filter_enable |-> rx_ninth_fin)
    else $error("filter passed a clear ninth bit");
  AST_FILTER_MATCH: assert property (@(posedge i_mclk) // R09 R13
    disable iff (i_sys_rst)
    rx_push && i_multiproc_filter_enable && i_nine_bit_mode |->
      (((rx_sh_q ^ i_slave_addr_value) & i_slave_addr_mask) == 8'h00 ||
       ((rx_sh_q | ~(i_slave_addr_value | i_slave_addr_mask)) == 8'hFF)))
    else $error("filter passed an unmatched address");
  AST_BCAST_ALL: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R14
    rx_stop && i_nine_bit_mode && rx_ninth_q && rx_sh_q == 8'hFF |->
      rx_accept)
    else $error("all-ones address refused");
  AST_BUF_HOLD: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R17 R18
    o_receive_done_flag && !i_rx_read |=>
      o_receive_done_flag && $stable(o_serial_data_buffer))
    else $error("held word changed before read");
  AST_DOUBLER_RST: assert property (@(posedge i_mclk) // R16
    i_sys_rst |=> !doubler_q)
    else $error("doubler not clear after reset");

  COV_ADDR_ACCEPT: cover property (@(posedge i_mclk)
    rx_push && i_multiproc_filter_enable && i_nine_bit_mode);
  COV_ADDR_REJECT: cover property (@(posedge i_mclk)
    rx_stop && !rx_accept);
  COV_TX_DONE: cover property (@(posedge i_mclk)
    o_tx_done && i_nine_bit_mode);
  COV_OVERRUN: cover property (@(posedge i_mclk) o_rx_overrun);

endmodule

// *** uart_pkg.sv ***
// Purpose: shared constants and types of the baud and address match block
// Assumes: one system clock; timer count clocks arrive as enable pulses
// Notes:   timer, sample and frame counts and the timer, doubler and shifter reset values are named here

// ****************************************
// package
// ****************************************
package uart_pkg;

  // timer geometry
  localparam int          NUM_WIDE      = 3;
  localparam int          T1_W          = 8;
  localparam int          WT_W          = 16;
  localparam logic [7:0]  T1_TOP        = 8'hFF;
  localparam logic [15:0] WT_TOP        = 16'hFFFF;
  localparam logic [7:0]  T1_RESET      = 8'h00;
  localparam logic [15:0] WT_RESET      = 16'h0000;

  // rate source select code of timer1; codes 1 to 3 pick the wide timers
  localparam logic [1:0]  SRC_TIMER1    = 2'h0;

  // baud logic
  localparam logic        DOUBLER_RESET = 1'b0;
  localparam logic [3:0]  SAMPLE_LAST   = 4'hF;
  localparam logic [3:0]  SAMPLE_MID    = 4'h7;
  localparam logic [5:0]  OVF_PER_BIT_SLOW = 6'h20;
  localparam logic [5:0]  OVF_PER_BIT_FAST = 6'h10;

  // framing
  localparam logic [3:0]  FRAME_BITS_9  = 4'hB;
  localparam logic [3:0]  FRAME_BITS_8  = 4'hA;
  localparam logic [2:0]  DATA_LAST     = 3'h7;
  localparam logic [10:0] TX_IDLE_LINE  = 11'h7FF;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // receive buffer
  localparam int          RXBUF_DEPTH   = 2;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_word_t;

  typedef enum {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_NINTH,
    RX_STOP
  } rx_state_t;

endpackage

// *** two_entry_buf.sv ***
// Purpose: small valid/ready buffer, two entries of flip-flops
// Assumes: synchronous active-high reset
// Notes:   in_ready drops only when both entries hold a word

module two_entry_buf
  import uart_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = RXBUF_DEPTH
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != FULL);
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
    end
  end

  // a push in the same cycle as a pop keeps the count: nothing is lost
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

// *** serial_peer.sv ***
// Purpose: far-side serial processor, master or slave on the line
// Assumes: bit time given in i_mclk cycles; line idles high
// Notes:   frames always 11 bits; in 8-bit mode the ninth slot is stop

// ****************************************
// peer
// ****************************************
module serial_peer (
  // clock
  input  wire logic i_mclk,
  // line
  input  wire logic i_line,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_line = 1'h1;

  // caller picks ninth: 1 for an address byte, 0 for data
  task automatic send(input int bt, input logic [7:0] d,
                      input logic n9);
    logic [10:0] f;
    f = {1'h1, n9, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      @(negedge i_mclk);
      o_line = f[i];
      repeat (bt - 1) @(negedge i_mclk);
    end
  endtask

  // samples mid-bit, so tick phase jitter of the sender is tolerated
  task automatic take(input int bt, output logic [10:0] f);
    int w;
    w = 0;
    while (i_line !== 1'h0 && w < 4000) begin
      @(negedge i_mclk);
      w++;
    end
    repeat (bt / 2) @(negedge i_mclk);
    for (int i = 0; i < 11; i++) begin
      f[i] = i_line;
      repeat (bt) @(negedge i_mclk);
    end
  endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench of the baud and address match block
// Assumes: count clocks pulse every cycle, reload all ones: 16 cycles/bit
// Notes:   wide timers first overflow 65536 ticks after reset

module testbench
  import uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0] sel;
    logic       dbl;
    logic [7:0] rl;
    logic [7:0] per;
  } rate_row_t;

  typedef struct packed {
    logic [7:0] a, m, d;
    logic       n9, flt, md, acc;
  } rx_row_t;

  // ****************************************
  // stimulus and tables
  // ****************************************
  logic             mclk = 1'h0, sys_rst = 1'h1, dbl = 1'h1;
  logic [1:0]       tsel = 2'h0, rsel = 2'h0;
  logic [7:0]       t1_rl = 8'hFF, addr = 8'h00, mask = 8'h00;
  logic [7:0]       tx_data = 8'h00;
  logic             nine = 1'h1, filt = 1'h0, rx_read = 1'h0;
  logic             tx_ninth = 1'h0, tx_valid = 1'h0, rxd;
  logic             o_tx_ready, o_tx_done, o_txd, o_rx_overrun;
  logic             o_receive_done_flag, o_received_ninth_bit;
  logic [7:0]       o_serial_data_buffer;
  logic [10:0]      frame;
  int               n_fail = 0, check_count = 0, cyc = 0;
  int               n_done = 0, n_ov = 0, per;

  // wide reloads: T2 all ones, T3 one below, T4 all ones
  rate_row_t rates [6] = '{
    '{2'h0, 1'h1, 8'hFF, 8'h10}, '{2'h0, 1'h0, 8'hFF, 8'h20},
    '{2'h0, 1'h1, 8'hFE, 8'h20}, '{2'h1, 1'h0, 8'hFF, 8'h10},
    '{2'h2, 1'h1, 8'hFF, 8'h20}, '{2'h3, 1'h0, 8'hFF, 8'h10}};

  rx_row_t rx_rows [10] = '{
    '{8'h35, 8'h0F, 8'hF5, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h35, 8'h0F, 8'hFF, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h35, 8'h0F, 8'h34, 1'h1, 1'h1, 1'h1, 1'h0},
    '{8'h35, 8'h0F, 8'h35, 1'h0, 1'h1, 1'h1, 1'h0},
    '{8'h35, 8'hF3, 8'hF5, 1'h1, 1'h1, 1'h1, 1'h0},
    '{8'h35, 8'hF3, 8'hFF, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h35, 8'hC0, 8'h3A, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h35, 8'hF3, 8'hF7, 1'h1, 1'h1, 1'h1, 1'h1},
    '{8'h35, 8'h0F, 8'h34, 1'h0, 1'h0, 1'h1, 1'h1},
    '{8'h35, 8'h0F, 8'h34, 1'h1, 1'h1, 1'h0, 1'h1}};

  uart_baud_and_address_match dut_u (
    .i_mclk                    (mclk),
    .i_sys_rst                 (sys_rst),
    .i_timer1_count_clock      (1'h1),
    .i_timer1_reload_byte      (t1_rl),
    .i_wide_timer_count_clock  (3'h7),
    .i_wide_timer_reload_value ({16'hFFFF, 16'hFFFE, 16'hFFFF}),
    .i_rate_doubler_bit        (dbl),
    .i_tx_rate_source_sel      (tsel),
    .i_rx_rate_source_sel      (rsel),
    .i_nine_bit_mode           (nine),
    .i_multiproc_filter_enable (filt),
    .i_slave_addr_value        (addr),
    .i_slave_addr_mask         (mask),
    .i_tx_data                 (tx_data),
    .i_tx_ninth                (tx_ninth),
    .i_tx_valid                (tx_valid),
    .o_tx_ready                (o_tx_ready),
    .o_tx_done                 (o_tx_done),
    .o_txd                     (o_txd),
    .i_rxd                     (rxd),
    .i_rx_read                 (rx_read),
    .o_receive_done_flag       (o_receive_done_flag),
    .o_serial_data_buffer      (o_serial_data_buffer),
    .o_received_ninth_bit      (o_received_ninth_bit),
    .o_rx_overrun              (o_rx_overrun)
  );

  serial_peer peer_u (
    .i_mclk (mclk),
    .i_line (o_txd),
    .o_line (rxd)
  );

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (o_tx_done === 1'h1) n_done++;
    if (o_rx_overrun === 1'h1) n_ov++;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // valid held across one rising edge; caller ensures the sender is idle
  task automatic tx_go(input logic [7:0] d, input logic n9);
    @(negedge mclk);
    tx_data = d;
    tx_ninth = n9;
    tx_valid = 1'h1;
    @(negedge mclk);
    tx_valid = 1'h0;
  endtask

  task automatic tx_idle();
    int w;
    w = 0;
    while (o_tx_ready !== 1'h1 && w < 5000) begin
      @(negedge mclk);
      w++;
    end
  endtask

  // d0 high time of byte 01 is exactly one bit
  task automatic meas(output int p);
    tx_go(8'h01, 1'h0);
    p = 0;
    while (o_txd !== 1'h1 && p < 200) begin
      @(negedge mclk);
      p++;
    end
    p = 0;
    while (o_txd === 1'h1 && p < 200) begin
      @(negedge mclk);
      p++;
    end
  endtask

  task automatic rd();
    rx_read = 1'h1;
    @(negedge mclk);
    rx_read = 1'h0;
    @(negedge mclk);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 1'h0;
    chk_val(o_txd, 1'h1);
    chk_val(o_tx_ready, 1'h1);
    chk_val(o_receive_done_flag, 1'h0);
    repeat (300) @(negedge mclk);
    $display("test reset done");
    foreach (rx_rows[i]) begin
      addr = rx_rows[i].a;
      mask = rx_rows[i].m;
      filt = rx_rows[i].flt;
      nine = rx_rows[i].md;
      peer_u.send(16, rx_rows[i].d, rx_rows[i].n9);
      chk_val(o_receive_done_flag, rx_rows[i].acc);
      if (rx_rows[i].acc) begin
        chk_val(o_serial_data_buffer, rx_rows[i].d);
        chk_val(o_received_ninth_bit, rx_rows[i].n9);
        rd();
        chk_val(o_receive_done_flag, 1'h0);
      end
    end
    $display("test address filter done");
    // no reads while three words arrive: third must be dropped
    filt = 1'h0;
    nine = 1'h1;
    for (int k = 1; k < 4; k++) peer_u.send(16, 8'(k * 17), 1'h0);
    chk_val(n_ov, 16'h0001);
    chk_val(o_serial_data_buffer, 8'h11);
    rd();
    chk_val(o_serial_data_buffer, 8'h22);
    rd();
    chk_val(o_receive_done_flag, 1'h0);
    $display("test buffer fill done");
    // address with filter on, data with filter off, then filter back on
    addr = 8'h35;
    mask = 8'h0F;
    filt = 1'h1;
    peer_u.send(16, 8'h35, 1'h1);
    chk_val(o_receive_done_flag, 1'h1);
    rd();
    filt = 1'h0;
    peer_u.send(16, 8'h5A, 1'h0);
    chk_val(o_serial_data_buffer, 8'h5A);
    rd();
    filt = 1'h1;
    peer_u.send(16, 8'h5A, 1'h0);
    chk_val(o_receive_done_flag, 1'h0);
    filt = 1'h0;
    $display("test message sequence done");
    for (int k = 0; k < 2; k++) begin
      nine = 1'(1 - k);
      tx_go(k ? 8'h3C : 8'hA5, 1'h1);
      peer_u.take(16, frame);
      chk_val(frame, {5'h00, 2'h3, k ? 8'h3C : 8'hA5, 1'h0});
      tx_idle();
    end
    chk_val(n_done, 16'h0002);
    $display("test tx framing done");
    nine = 1'h1;
    foreach (rates[i]) begin
      if (i == 3) while (cyc < 66000) @(negedge mclk);
      tsel = rates[i].sel;
      dbl = rates[i].dbl;
      t1_rl = rates[i].rl;
      meas(per);
      chk_val(per, rates[i].per);
      tx_idle();
    end
    $display("test rates done");
    // tx on the slow wide timer while rx stays on the fast timer1
    tsel = 2'h2;
    dbl = 1'h1;
    t1_rl = 8'hFF;
    meas(per);
    chk_val(per, 16'h0020);
    tx_idle();
    peer_u.send(16, 8'hC3, 1'h0);
    chk_val(o_serial_data_buffer, 8'hC3);
    rd();
    $display("test independent sources done");
    complete_run();
  end
endmodule
